// ===== rtl/ccs_clock_status.v
`include "ccs_defines.vh"
`default_nettype none
module ccs_clock_status #(
   parameter [31:0] DEB_BASE_CYC = `CCS_DEB_BASE_MS * `CCS_CLK_KHZ
) (
   input wire clk,
   input wire rst,
   input wire [9:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   input wire [1:0] path_master,
   input wire high_rate_select,
   input wire [1:0] frame_clk_i,
   output wire [1:0] frame_clk_o,
   output wire [1:0] frame_clk_oe_n,
   output wire [1:0] oversample_tick,
   output wire [1:0] pll_locked,
   output wire pclk_en,
   input wire clip_event,
   input wire slew_done_event,
   input wire soft_seq_done,
   input wire [1:0] jack_sense_pin,
   input wire [15:0] aux_sample,
   input wire aux_valid,
   output wire aux_calibration_select,
   output wire irq_o,
   output reg irq_oe_n
);

////////////////////////////////////////////////////////////////////////
// register decode
wire [1:0] page = reg_addr[9:8];
wire [7:0] ra = reg_addr[7:0];
// 0xff is kept off the four-wire page
wire acc_ok = (page == `CCS_PAGE_2W) |
   ((page == `CCS_PAGE_4W) & (ra != `CCS_ADDR_NO_4W));
wire wr_ok = reg_wr & acc_ok;
wire rd_flags = reg_rd & acc_ok & (ra == `CCS_ADDR_FLAGS);

reg [7:0] irq_en_q;
reg [7:0] sysclk_q;
reg [7:0] p1_hi_q;
reg [7:0] p1_lo_q;
reg [7:0] p2_hi_q;
reg [7:0] p2_lo_q;
reg aux_hold_q;
reg aux_cal_q;
reg jack_en_q;
reg [1:0] jack_deb_q;

// writable registers; offsets 0x00-0x03 have no write path
always @(posedge clk) begin
   if (rst) begin
      irq_en_q <= `CCS_RST_BYTE;
      sysclk_q <= `CCS_RST_BYTE;
      p1_hi_q <= `CCS_RST_BYTE;
      p1_lo_q <= `CCS_RST_BYTE;
      p2_hi_q <= `CCS_RST_BYTE;
      p2_lo_q <= `CCS_RST_BYTE;
      aux_hold_q <= 1'b0;
      aux_cal_q <= 1'b0;
      jack_en_q <= 1'b0;
      jack_deb_q <= 2'b00;
   end else if (wr_ok) begin
      case (ra)
         `CCS_ADDR_IRQ_EN: irq_en_q <= reg_wdata & `CCS_FLAG_MASK;
         `CCS_ADDR_SYSCLK: sysclk_q <= {2'b00, reg_wdata[5:0]};
         `CCS_ADDR_P1_HI: p1_hi_q <= reg_wdata;
         `CCS_ADDR_P1_LO: p1_lo_q <= reg_wdata;
         `CCS_ADDR_P2_HI: p2_hi_q <= reg_wdata;
         `CCS_ADDR_P2_LO: p2_lo_q <= reg_wdata;
         `CCS_ADDR_AUX_CFG: begin
            aux_hold_q <= reg_wdata[`CCS_BIT_AUX_HOLD];
            aux_cal_q <= reg_wdata[`CCS_BIT_AUX_CAL];
         end
         `CCS_ADDR_JACK_CFG: begin
            jack_en_q <= reg_wdata[`CCS_BIT_JACK_EN];
            jack_deb_q <= reg_wdata[1:0];
         end
         default: ;
      endcase
   end
end

assign aux_calibration_select = aux_cal_q;

////////////////////////////////////////////////////////////////////////
// prescaler: internal clock as an enable pulse
wire [1:0] prescale_select = sysclk_q[5:4];
wire [3:0] exact_ratio_select = sysclk_q[3:0];
reg [1:0] pre_cnt_q;

always @(posedge clk) begin
   if (rst)
      pre_cnt_q <= 2'b00;
   else
      pre_cnt_q <= pre_cnt_q + 2'b01;
end

// code 00 holds the enable low, freezing every path divider; the prescale counter and slave realign still run
assign pclk_en = (prescale_select == `CCS_PS_DIV1) |
   ((prescale_select == `CCS_PS_DIV2) & pre_cnt_q[0]) |
   ((prescale_select == `CCS_PS_DIV4) & (&pre_cnt_q));

// fixed ratio lookup, doubled so 812.5 stays exact
reg [12:0] ratio2;
always @* begin
   case (exact_ratio_select[2:0])
      3'h0: ratio2 = `CCS_R2_8;
      3'h1: ratio2 = `CCS_R2_9;
      3'h2: ratio2 = `CCS_R2_A;
      3'h3: ratio2 = `CCS_R2_B;
      3'h4: ratio2 = `CCS_R2_C;
      3'h5: ratio2 = `CCS_R2_D;
      3'h6: ratio2 = `CCS_R2_E;
      default: ratio2 = `CCS_R2_F;
   endcase
end
// codes 0-7 are not guarded; only bit 3 picks exact mode
wire exact_mode = exact_ratio_select[3];

////////////////////////////////////////////////////////////////////////
// per-path frame rate generation and digital PLL
wire [1:0] unlock_pulse;

genvar g;
generate
for (g = 0; g < 2; g = g + 1) begin : g_path
   wire [7:0] hi = (g == 0) ? p1_hi_q : p2_hi_q;
   wire [7:0] lo = (g == 0) ? p1_lo_q : p2_lo_q;
   wire [14:0] coef_prog = {hi[6:0], lo};
   wire pll_en = hi[`CCS_BIT_PLL_EN];
   wire rapid = lo[`CCS_BIT_RAPID];
   wire exact = (g == 0) & exact_mode;
   wire master = path_master[g];
   wire [6:0] target = ((g == 1) & high_rate_select) ?
      `CCS_TICKS_HIGH : `CCS_TICKS_NORM;
   // on path 1 only, exact mode overrides the PLL and divider controls
   wire use_pll = ~master & pll_en & ~exact;
   reg fs1_q;
   reg fs2_q;
   reg fs3_q;
   reg [15:0] acc_q;
   reg [12:0] ex_acc_q;
   reg [6:0] cnt_q;
   reg [14:0] coef_q;
   reg [2:0] lockc_q;
   reg locked_q;
   reg unl_q;
   reg fclk_q;
   reg tick_q;
   wire [14:0] eff_coef = use_pll ? coef_q : coef_prog;
   wire [16:0] sum = {1'b0, acc_q} + {2'b00, eff_coef};
   wire ovf = sum[16];
   wire [12:0] ex_next = ex_acc_q + `CCS_EX_STEP;
   wire [6:0] cnt_inc = cnt_q + 7'd1;
   wire [6:0] cnt_wrap = (cnt_inc == target) ? 7'd0 : cnt_inc;
   wire ext_rise = fs2_q & ~fs3_q;
   wire near = (cnt_inc >= target) & (cnt_q <= target + 7'd1);
   wire far = (cnt_q + 7'd2 < target) | (cnt_q > target + 7'd2);
   wire [14:0] step = far ? `CCS_PLL_COARSE : `CCS_PLL_FINE;

   always @(posedge clk) begin
      if (rst) begin
         fs1_q <= 1'b0;
         fs2_q <= 1'b0;
         fs3_q <= 1'b0;
      end else begin
         fs1_q <= frame_clk_i[g];
         fs2_q <= fs1_q;
         fs3_q <= fs2_q;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         acc_q <= 16'h0000;
         ex_acc_q <= 13'd0;
         cnt_q <= 7'd0;
         coef_q <= `CCS_PLL_MID;
         lockc_q <= 3'd0;
         locked_q <= 1'b0;
         unl_q <= 1'b0;
         fclk_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         unl_q <= 1'b0;
         tick_q <= pclk_en & ovf & ~exact;
         // preload: rapid starts the loop at the programmed ratio, otherwise at CCS_PLL_MID
         if (!use_pll) begin
            coef_q <= rapid ? coef_prog : `CCS_PLL_MID;
            lockc_q <= 3'd0;
            locked_q <= 1'b0;
         end
         // the divider block below advances on the internal clock only; the slave realign after it does not
         if (pclk_en) begin
            if (exact) begin
               if (ex_next >= ratio2) begin
                  ex_acc_q <= ex_next - ratio2;
                  fclk_q <= ~fclk_q;
               end else begin
                  ex_acc_q <= ex_next;
               end
            end else begin
               acc_q <= sum[15:0];
               if (ovf) begin
                  if (master) begin
                     cnt_q <= cnt_wrap;
                     fclk_q <= (cnt_wrap < (target >> 1));
                  end else if (cnt_q != 7'h7f) begin
                     cnt_q <= cnt_inc;
                  end
               end
            end
         end
         // slave: external edge realigns the sample count
         if (ext_rise & ~master & ~exact) begin
            cnt_q <= 7'd0;
            if (use_pll) begin
               if (cnt_q < target)
                  coef_q <= coef_q + step;
               else if (cnt_q > target)
                  coef_q <= coef_q - step;
               if (near) begin
                  if (lockc_q == `CCS_LOCK_FRAMES)
                     locked_q <= 1'b1;
                  else
                     lockc_q <= lockc_q + 3'd1;
               end else begin
                  lockc_q <= 3'd0;
               end
               if (locked_q & far) begin
                  locked_q <= 1'b0;
                  unl_q <= 1'b1;
               end
            end
         end
      end
   end

   assign frame_clk_o[g] = fclk_q;
   assign frame_clk_oe_n[g] = ~master;
   assign oversample_tick[g] = tick_q;
   assign pll_locked[g] = locked_q;
   assign unlock_pulse[g] = unl_q;
end
endgenerate

////////////////////////////////////////////////////////////////////////
// jack sense: synchronise, debounce, detect change
reg [1:0] js1_q;
reg [1:0] js2_q;
reg [1:0] jstable_q;
reg [31:0] deb_cnt_q;
reg jack_chg_q;
// longer codes double the base time each step
wire [31:0] deb_limit = DEB_BASE_CYC << jack_deb_q;

always @(posedge clk) begin
   if (rst) begin
      js1_q <= 2'b00;
      js2_q <= 2'b00;
   end else begin
      js1_q <= jack_sense_pin;
      js2_q <= js1_q;
   end
end

always @(posedge clk) begin
   if (rst) begin
      jstable_q <= 2'b00;
      deb_cnt_q <= 32'd0;
      jack_chg_q <= 1'b0;
   end else begin
      jack_chg_q <= 1'b0;
      if (!jack_en_q | (js2_q == jstable_q)) begin
         deb_cnt_q <= 32'd0;
      end else if (deb_cnt_q >= deb_limit) begin
         jstable_q <= js2_q;
         deb_cnt_q <= 32'd0;
         jack_chg_q <= 1'b1;
      end else begin
         deb_cnt_q <= deb_cnt_q + 32'd1;
      end
   end
end

// raw, undebounced state; 10 passes through as read
wire [1:0] jack_sense_state = jack_en_q ? js2_q : 2'b00;

////////////////////////////////////////////////////////////////////////
// aux measurement capture
reg [15:0] aux_q;
always @(posedge clk) begin
   if (rst)
      aux_q <= 16'h0000;
   else if (aux_valid & ~aux_hold_q)
      aux_q <= aux_sample;
end

////////////////////////////////////////////////////////////////////////
// status flags and interrupt
reg [7:0] flags_q;
reg [7:0] set_vec;
always @* begin
   set_vec = 8'h00;
   set_vec[`CCS_BIT_CLIP] = clip_event;
   set_vec[`CCS_BIT_SLEW] = slew_done_event | soft_seq_done;
   set_vec[`CCS_BIT_UNLOCK] = |unlock_pulse;
   set_vec[`CCS_BIT_JACK] = jack_chg_q;
end

// set wins over the read clear so no event is lost
wire [7:0] flags_d = ((rd_flags ? 8'h00 : flags_q) | set_vec) &
   `CCS_FLAG_MASK;

always @(posedge clk) begin
   if (rst) begin
      flags_q <= `CCS_RST_BYTE;
      irq_oe_n <= 1'b1;
   end else begin
      flags_q <= flags_d;
      irq_oe_n <= ~|(flags_d & irq_en_q);
   end
end

// open drain: only ever pulls low
assign irq_o = 1'b0;

////////////////////////////////////////////////////////////////////////
// read data
reg [7:0] rd_mux;
always @* begin
   rd_mux = 8'h00;
   case (ra)
      `CCS_ADDR_FLAGS: rd_mux = flags_q;
      `CCS_ADDR_JACK: rd_mux = {jack_sense_state, 6'b000000};
      `CCS_ADDR_AUX_HI: rd_mux = aux_q[15:8];
      `CCS_ADDR_AUX_LO: rd_mux = aux_q[7:0];
      `CCS_ADDR_IRQ_EN: rd_mux = irq_en_q;
      `CCS_ADDR_SYSCLK: rd_mux = sysclk_q;
      `CCS_ADDR_P1_HI: rd_mux = p1_hi_q;
      `CCS_ADDR_P1_LO: rd_mux = p1_lo_q;
      `CCS_ADDR_P2_HI: rd_mux = p2_hi_q;
      `CCS_ADDR_P2_LO: rd_mux = p2_lo_q;
      `CCS_ADDR_AUX_CFG: rd_mux = {4'h0, aux_hold_q, aux_cal_q, 2'b00};
      `CCS_ADDR_JACK_CFG: rd_mux = {jack_en_q, 5'b00000, jack_deb_q};
      default: rd_mux = 8'h00;
   endcase
   if (!acc_ok)
      rd_mux = 8'h00;
end

always @(posedge clk) begin
   if (rst)
      reg_rdata <= 8'h00;
   else if (reg_rd)
      reg_rdata <= rd_mux;
end

endmodule // ccs_clock_status
`default_nettype wire

// ===== rtl/ccs_defines.vh
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
// register offsets on the two-wire map
`define CCS_ADDR_FLAGS 8'h00
`define CCS_ADDR_JACK 8'h01
`define CCS_ADDR_AUX_HI 8'h02
`define CCS_ADDR_AUX_LO 8'h03
`define CCS_ADDR_IRQ_EN 8'h04
`define CCS_ADDR_SYSCLK 8'h05
`define CCS_ADDR_P1_HI 8'h06
`define CCS_ADDR_P1_LO 8'h07
`define CCS_ADDR_P2_HI 8'h0b
`define CCS_ADDR_P2_LO 8'h0c
`define CCS_ADDR_AUX_CFG 8'h22
`define CCS_ADDR_JACK_CFG 8'h25
// four-wire page (0x200) and the one offset it cannot reach
`define CCS_PAGE_2W 2'b00
`define CCS_PAGE_4W 2'b10
`define CCS_ADDR_NO_4W 8'hff
// status and enable bit positions
`define CCS_BIT_CLIP 7
`define CCS_BIT_SLEW 6
`define CCS_BIT_UNLOCK 5
`define CCS_BIT_JACK 1
`define CCS_FLAG_MASK 8'he2
`define CCS_RST_BYTE 8'h00
// other field positions
`define CCS_BIT_PLL_EN 7
`define CCS_BIT_RAPID 0
`define CCS_BIT_AUX_HOLD 3
`define CCS_BIT_AUX_CAL 2
`define CCS_BIT_JACK_EN 7
// prescale codes
`define CCS_PS_OFF 2'b00
`define CCS_PS_DIV1 2'b01
`define CCS_PS_DIV2 2'b10
`define CCS_PS_DIV4 2'b11
// frame timing
`define CCS_TICKS_NORM 7'd96
`define CCS_TICKS_HIGH 7'd48
`define CCS_PLL_MID 15'h4000
`define CCS_PLL_FINE 15'h0001
`define CCS_PLL_COARSE 15'h0010
`define CCS_LOCK_FRAMES 3'd4
// doubled exact ratios, codes 0x8..0xf
`define CCS_R2_8 13'd3000
`define CCS_R2_9 13'd1500
`define CCS_R2_A 13'd3250
`define CCS_R2_B 13'd1625
`define CCS_R2_C 13'd4000
`define CCS_R2_D 13'd2000
`define CCS_R2_E 13'd4800
`define CCS_R2_F 13'd2400
`define CCS_EX_STEP 13'd4
// debounce base time and clock rate
`define CCS_CLK_KHZ 250000
`define CCS_DEB_BASE_MS 25
`endif

// ===== sim/ccs_clock_status_sva.sv
`default_nettype none
module ccs_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [9:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] path_master,
   input wire logic [1:0] frame_clk_oe_n,
   input wire logic [1:0] oversample_tick,
   input wire logic pclk_en,
   input wire logic clip_event,
   input wire logic slew_done_event,
   input wire logic soft_seq_done,
   input wire logic irq_o,
   input wire logic irq_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] en_q;
   logic [1:0] ps_q;
   wire logic map_ok = reg_addr[9:8] == 2'b00 ||
      (reg_addr[9:8] == 2'b10 && reg_addr[7:0] != 8'hff);
   wire logic rd0 = reg_rd && map_ok && reg_addr[7:0] == 8'h00;
   // shadow of enable and prescale fields, so gating can be judged
   always @(posedge clk) begin
      if (rst) begin
         en_q <= 8'h00;
         ps_q <= 2'b00;
      end else if (reg_wr && map_ok) begin
         if (reg_addr[7:0] == 8'h04) en_q <= reg_wdata;
         if (reg_addr[7:0] == 8'h05) ps_q <= reg_wdata[5:4];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_quiet;
      !clip_event && !slew_done_event && !soft_seq_done;
   endsequence
   a_irq_open_drain: assert property (irq_o == 1'b0) else $error("irq data not low");
   a_oe_follows_mode: assert property (frame_clk_oe_n == ~path_master)
      else $error("frame clock drive wrong");
   a_clip_raises_irq: assert property (clip_event && en_q[7] && !reg_wr |=> !irq_oe_n)
      else $error("clip did not pull irq");
   a_irq_held_low: assert property (!irq_oe_n && !rd0 && !reg_wr |=> !irq_oe_n)
      else $error("irq released without read");
   a_read_clears: assert property ((rd0 && !clip_event && !slew_done_event && !soft_seq_done)
      ##1 s_quiet |-> ##[0:1] irq_oe_n) else $error("irq kept after read");
   a_ff_unreached: assert property (reg_rd && reg_addr == 10'h2ff |=> reg_rdata == 8'h00)
      else $error("offset ff answered on four-wire page");
   a_pclk_stopped: assert property (ps_q == 2'b00 |-> !pclk_en) else $error("pclk ran");
   a_pclk_div4: assert property (pclk_en && ps_q == 2'b11 && $past(ps_q, 4) == 2'b11
      |-> !$past(pclk_en, 1) && !$past(pclk_en, 2) && !$past(pclk_en, 3))
      else $error("pclk too fast for divide by four");
   a_tick_spacing: assert property (oversample_tick[0] |=> !oversample_tick[0])
      else $error("ticks back to back");
endmodule // ccs_chk
bind ccs_clock_status ccs_chk u_chk (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .path_master(path_master),
   .frame_clk_oe_n(frame_clk_oe_n), .oversample_tick(oversample_tick), .pclk_en(pclk_en),
   .clip_event(clip_event), .slew_done_event(slew_done_event), .soft_seq_done(soft_seq_done),
   .irq_o(irq_o), .irq_oe_n(irq_oe_n)
);
`default_nettype wire

// ===== sim/ccs_frame_src.sv
`default_nettype none
module ccs_frame_src (
   input wire logic clk,
   input wire logic run,
   input wire logic [15:0] half_cyc,
   output logic frame_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] cnt_q;
   // far-side frame master; clock stands still outside a run
   // compare with >= so a shortened half period takes hold at once
   always @(posedge clk) begin
      if (!run) begin
         cnt_q <= 16'h0000;
         frame_clk <= 1'b0;
      end else if (cnt_q >= half_cyc - 16'h0001) begin
         cnt_q <= 16'h0000;
         frame_clk <= ~frame_clk;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule // ccs_frame_src
`default_nettype wire

// ===== sim/ccs_tb.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, high_rate_select = 0, run = 0;
   logic clip_event = 0, slew_done_event = 0, soft_seq_done = 0, aux_valid = 0;
   logic [9:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0;
   logic [1:0] path_master = 0, jack_sense_pin = 0;
   logic [15:0] aux_sample = 0, half_cyc = 16'd192;
   wire logic [7:0] reg_rdata;
   wire logic [1:0] fco, fco_oe_n, tick, locked;
   wire logic fsrc, pclk_en, cal, irq_o, irq_oe_n;
   int bad_count = 0, n_tests = 0, cyc = 0, c_pclk, c_tick, c_r0, c_r1, w;
   localparam logic [15:0] PCNT [4] = '{16'd0, 16'd40, 16'd20, 16'd10};
   ccs_clock_status #(.DEB_BASE_CYC(32'd8)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .path_master(path_master), .high_rate_select(high_rate_select),
      .frame_clk_i({1'b0, fsrc}), .frame_clk_o(fco), .frame_clk_oe_n(fco_oe_n),
      .oversample_tick(tick), .pll_locked(locked), .pclk_en(pclk_en),
      .clip_event(clip_event), .slew_done_event(slew_done_event), .soft_seq_done(soft_seq_done),
      .jack_sense_pin(jack_sense_pin), .aux_sample(aux_sample), .aux_valid(aux_valid),
      .aux_calibration_select(cal), .irq_o(irq_o), .irq_oe_n(irq_oe_n));
   ccs_frame_src u_src (.clk(clk), .run(run), .half_cyc(half_cyc), .frame_clk(fsrc));
   always #2 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         close_out();
      end
   end
   ////////////////////////////////////////
   task automatic close_out();
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge clk);
      #1 reg_wr = 0;
   endtask
   // read, then compare the masked byte
   task automatic rdc(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      #1 {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge clk);
      #1 reg_rd = 0;
      chk($sformatf("reg_%h", a), e, reg_rdata & m);
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      #1 {clip_event, slew_done_event, soft_seq_done} = {k == 0, k == 1, k == 2};
      @(posedge clk);
      #1 {clip_event, slew_done_event, soft_seq_done} = 3'b000;
   endtask
   task automatic sample(input logic [15:0] v);
      @(posedge clk);
      #1 {aux_sample, aux_valid} = {v, 1'b1};
      @(posedge clk);
      #1 aux_valid = 0;
   endtask
   task automatic measure(input int n);
      logic p0, p1;
      // start off the edge so the first sample has a settled reference
      @(posedge clk);
      #1 {c_pclk, c_tick, c_r0, c_r1} = 0;
      {p0, p1} = {fco[0], fco[1]};
      repeat (n) begin
         @(posedge clk);
         #1 c_pclk += pclk_en;
         c_tick += tick[0];
         c_r0 += fco[0] && !p0;
         c_r1 += fco[1] && !p1;
         {p0, p1} = {fco[0], fco[1]};
      end
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 0;
      wr(10'h004, 8'hff);
      rdc(10'h004, 8'he2, 8'hff);
      wr(10'h000, 8'hff);
      rdc(10'h000, 8'h00, 8'hff);
      wr(10'h003, 8'hff);
      rdc(10'h003, 8'h00, 8'hff);
      wr(10'h205, 8'h10);
      rdc(10'h005, 8'h10, 8'hff);
      rdc(10'h2ff, 8'h00, 8'hff);
      // each prescale code over a 40-cycle window
      for (int i = 0; i < 4; i++) begin
         wr(10'h005, {2'b00, i[1:0], 4'h0});
         measure(40);
         chk("pclk", PCNT[i], c_pclk[15:0]);
      end
      pulse(0);
      chk("irq_low", 16'h0, irq_oe_n);
      rdc(10'h000, 8'h80, 8'hff);
      chk("irq_free", 16'h1, irq_oe_n);
      pulse(1);
      rdc(10'h000, 8'h40, 8'hff);
      pulse(2);
      rdc(10'h000, 8'h40, 8'hff);
      wr(10'h004, 8'h20);
      pulse(0);
      chk("irq_masked", 16'h1, irq_oe_n);
      @(posedge clk);
      #1 {reg_addr, reg_rd, clip_event} = {10'h000, 1'b1, 1'b1};
      @(posedge clk);
      #1 {reg_rd, clip_event} = 2'b00;
      rdc(10'h000, 8'h80, 8'hff);
      wr(10'h004, 8'h00);
      // jack sense, debounce code 0
      wr(10'h025, 8'h80);
      rdc(10'h000, 8'h00, 8'hff);
      jack_sense_pin = 2'b01;
      repeat (40) @(posedge clk);
      rdc(10'h001, 8'h40, 8'hff);
      rdc(10'h000, 8'h02, 8'hff);
      sample(16'h8123);
      wr(10'h022, 8'h08);
      sample(16'h1111);
      rdc(10'h002, 8'h81, 8'hff);
      rdc(10'h003, 8'h23, 8'hff);
      wr(10'h022, 8'h04);
      chk("cal", 16'h1, cal);
      // both paths master, coefficient 0x4000: a tick every 4 cycles
      wr(10'h005, 8'h10);
      {path_master, high_rate_select} = 3'b111;
      wr(10'h006, 8'h40);
      wr(10'h007, 8'h00);
      wr(10'h00b, 8'h40);
      wr(10'h00c, 8'h00);
      repeat (400) @(posedge clk);
      measure(3840);
      chk("ticks", 16'd960, c_tick[15:0]);
      chk("frames1", 16'd10, c_r0[15:0]);
      chk("frames2", 16'd20, c_r1[15:0]);
      wr(10'h005, 8'h19);
      repeat (800) @(posedge clk);
      measure(7500);
      chk("exact", 16'd10, c_r0[15:0]);
      // slave path 1 with rapid-lock pll
      wr(10'h005, 8'h10);
      path_master = 2'b00;
      wr(10'h007, 8'h01);
      wr(10'h006, 8'hc0);
      run = 1;
      w = 0;
      while (locked[0] !== 1'b1 && w < 20000) begin
         @(posedge clk);
         #1 w++;
      end
      chk("lock", 16'h1, locked[0]);
      rdc(10'h000, 8'h00, 8'hff);
      half_cyc = 16'd100;
      repeat (3000) @(posedge clk);
      rdc(10'h000, 8'h20, 8'h20);
      close_out();
   end
endmodule // testbench
`default_nettype wire
